// ### rtl/input_loss_monitor_write_lock.sv
// input-loss monitor, clock parking and write-guarded register port
`timescale 1ns/1ps
module input_loss_monitor_write_lock #(
   parameter logic [6:0] BUS_ADDR      = input_loss_monitor_pkg::DEFAULT_BUS_ADDR,
   parameter int         ABSENT_CYCLES = input_loss_monitor_pkg::ABSENT_CYCLES
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic referenceInputClock,
   input  wire logic busClockIn,
   input  wire logic busDataIn,
   output logic      busDataOut_ff,
   output logic      busDataOe_ff,
   output logic      clockAbsentPinOut_ff,
   output logic      clockAbsentPinOe_ff,
   output logic      clkOutP_ff,
   output logic      clkOutN_ff,
   output logic      writeGuardActive_ff
);

   logic                              absent;
   logic                              firstEdgeSeen;
   logic                              refLevel;
   logic                              absentDly_ff;
   logic                              lossPulse;
   logic                              inputAbsentEvent_ff;
   logic                              clearableWriteGuard_ff;
   logic                              nonclearGuard_ff;
   logic                              sclMeta_ff;
   logic                              sclSync_ff;
   logic                              sclDly_ff;
   logic                              sdaMeta_ff;
   logic                              sdaSync_ff;
   logic                              sdaDly_ff;
   logic                              sclRise;
   logic                              sclFall;
   logic                              startSeen;
   logic                              stopSeen;
   input_loss_monitor_pkg::bus_state_t state_ff;
   logic [3:0]                        bitCnt_ff;
   logic [7:0]                        rxShift_ff;
   logic [7:0]                        txShift_ff;
   logic [7:0]                        cmd_ff;
   logic                              readMode_ff;
   logic                              hostAcked_ff;
   logic                              writeStrobe;
   logic                              writeBlocked;
   logic [7:0]                        readByte;

   input_absence_detector #(
      .ABSENT_CYCLES (ABSENT_CYCLES),
      .CNT_W         (input_loss_monitor_pkg::ABSENT_CNT_W)
   ) u_detector (
      .clock               (clock),
      .sys_rst             (sys_rst),
      .referenceInputClock (referenceInputClock),
      .absent_ff           (absent),
      .firstEdgeSeen_ff    (firstEdgeSeen),
      .refLevel_ff         (refLevel)
   );

   // a loss is a fall out of the present state, not the absent state after reset
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         absentDly_ff <= 1'b1;
      else
         absentDly_ff <= absent;
   end

   assign lossPulse = absent & ~absentDly_ff;

   // open-drain loss pin: enable pulls low, released until the first edge
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clockAbsentPinOut_ff <= 1'b0;
         clockAbsentPinOe_ff  <= 1'b0;
      end
      else
      begin
         clockAbsentPinOut_ff <= 1'b0;
         clockAbsentPinOe_ff  <= firstEdgeSeen & absent;
      end
   end

   // clock path parks low/low rather than floating or toggling
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         clkOutP_ff <= 1'b0;
         clkOutN_ff <= 1'b0;
      end
      else if (absent)
      begin
         clkOutP_ff <= 1'b0;
         clkOutN_ff <= 1'b0;
      end
      else
      begin
         clkOutP_ff <= refLevel;
         clkOutN_ff <= ~refLevel;
      end
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         sclMeta_ff <= 1'b1;
         sclSync_ff <= 1'b1;
         sclDly_ff  <= 1'b1;
         sdaMeta_ff <= 1'b1;
         sdaSync_ff <= 1'b1;
         sdaDly_ff  <= 1'b1;
      end
      else
      begin
         sclMeta_ff <= busClockIn;
         sclSync_ff <= sclMeta_ff;
         sclDly_ff  <= sclSync_ff;
         sdaMeta_ff <= busDataIn;
         sdaSync_ff <= sdaMeta_ff;
         sdaDly_ff  <= sdaSync_ff;
      end
   end

   assign sclRise   = sclSync_ff & ~sclDly_ff;
   assign sclFall   = ~sclSync_ff & sclDly_ff;
   assign startSeen = sclSync_ff & sclDly_ff & sdaDly_ff & ~sdaSync_ff;
   assign stopSeen  = sclSync_ff & sclDly_ff & ~sdaDly_ff & sdaSync_ff;

   assign writeStrobe = (state_ff == input_loss_monitor_pkg::BUS_WDATA)
                        && sclFall && (bitCnt_ff == 4'd8);
   assign writeBlocked = clearableWriteGuard_ff | nonclearGuard_ff;

   // read mux: guard bit and event bit, reserved bits read zero
   always_comb
   begin
      readByte = 8'h00;
      if (cmd_ff == input_loss_monitor_pkg::EVENT_GUARD_OFFSET)
      begin
         readByte[input_loss_monitor_pkg::CLEARABLE_GUARD_BIT] = clearableWriteGuard_ff;
         readByte[input_loss_monitor_pkg::INPUT_EVENT_BIT]     = inputAbsentEvent_ff;
      end
      else if (cmd_ff == input_loss_monitor_pkg::NONCLEAR_GUARD_OFFSET)
         readByte[input_loss_monitor_pkg::NONCLEAR_GUARD_BIT] = nonclearGuard_ff;
   end

   // byte-level bus engine; ack and read bits change on the falling clock, and start or stop releases the drive
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_ff      <= input_loss_monitor_pkg::BUS_IDLE;
         bitCnt_ff     <= 4'd0;
         rxShift_ff    <= 8'h00;
         txShift_ff    <= 8'h00;
         cmd_ff        <= 8'h00;
         readMode_ff   <= 1'b0;
         hostAcked_ff  <= 1'b0;
         busDataOut_ff <= 1'b0;
         busDataOe_ff  <= 1'b0;
      end
      else if (startSeen)
      begin
         state_ff     <= input_loss_monitor_pkg::BUS_ADDR;
         bitCnt_ff    <= 4'd0;
         busDataOe_ff <= 1'b0;
      end
      else if (stopSeen)
      begin
         state_ff     <= input_loss_monitor_pkg::BUS_IDLE;
         busDataOe_ff <= 1'b0;
      end
      else if (sclRise)
      begin
         if (state_ff == input_loss_monitor_pkg::BUS_RACK)
            hostAcked_ff <= ~sdaSync_ff;
         else if ((state_ff == input_loss_monitor_pkg::BUS_ADDR
                   || state_ff == input_loss_monitor_pkg::BUS_CMD
                   || state_ff == input_loss_monitor_pkg::BUS_WDATA) && bitCnt_ff != 4'd8)
         begin
            rxShift_ff <= {rxShift_ff[6:0], sdaSync_ff};
            bitCnt_ff  <= bitCnt_ff + 4'd1;
         end
      end
      else if (sclFall)
      begin
         case (state_ff)
            input_loss_monitor_pkg::BUS_ADDR:
               if (bitCnt_ff == 4'd8)
               begin
                  if (rxShift_ff[7:1] == BUS_ADDR)
                  begin
                     readMode_ff  <= rxShift_ff[0];
                     busDataOe_ff <= 1'b1;
                     state_ff     <= input_loss_monitor_pkg::BUS_ACK_ADDR;
                  end
                  else
                     state_ff <= input_loss_monitor_pkg::BUS_IDLE;
               end
            input_loss_monitor_pkg::BUS_ACK_ADDR:
            begin
               bitCnt_ff <= 4'd0;
               if (readMode_ff)
               begin
                  busDataOe_ff <= ~readByte[7];
                  txShift_ff   <= {readByte[6:0], 1'b0};
                  bitCnt_ff    <= 4'd1;
                  state_ff     <= input_loss_monitor_pkg::BUS_RDATA;
               end
               else
               begin
                  busDataOe_ff <= 1'b0;
                  state_ff     <= input_loss_monitor_pkg::BUS_CMD;
               end
            end
            input_loss_monitor_pkg::BUS_CMD:
               if (bitCnt_ff == 4'd8)
               begin
                  cmd_ff       <= rxShift_ff;
                  busDataOe_ff <= 1'b1;
                  state_ff     <= input_loss_monitor_pkg::BUS_ACK_CMD;
               end
            input_loss_monitor_pkg::BUS_ACK_CMD:
            begin
               busDataOe_ff <= 1'b0;
               bitCnt_ff    <= 4'd0;
               state_ff     <= input_loss_monitor_pkg::BUS_WDATA;
            end
            input_loss_monitor_pkg::BUS_WDATA:
               if (bitCnt_ff == 4'd8)
               begin
                  busDataOe_ff <= 1'b1;
                  state_ff     <= input_loss_monitor_pkg::BUS_ACK_DATA;
               end
            input_loss_monitor_pkg::BUS_ACK_DATA:
            begin
               busDataOe_ff <= 1'b0;
               bitCnt_ff    <= 4'd0;
               cmd_ff       <= cmd_ff + 8'd1;
               state_ff     <= input_loss_monitor_pkg::BUS_WDATA;
            end
            input_loss_monitor_pkg::BUS_RDATA:
               if (bitCnt_ff == 4'd8)
               begin
                  busDataOe_ff <= 1'b0;
                  cmd_ff       <= cmd_ff + 8'd1;
                  state_ff     <= input_loss_monitor_pkg::BUS_RACK;
               end
               else
               begin
                  busDataOe_ff <= ~txShift_ff[7];
                  txShift_ff   <= {txShift_ff[6:0], 1'b0};
                  bitCnt_ff    <= bitCnt_ff + 4'd1;
               end
            input_loss_monitor_pkg::BUS_RACK:
               if (hostAcked_ff)
               begin
                  busDataOe_ff <= ~readByte[7];
                  txShift_ff   <= {readByte[6:0], 1'b0};
                  bitCnt_ff    <= 4'd1;
                  state_ff     <= input_loss_monitor_pkg::BUS_RDATA;
               end
               else
                  state_ff <= input_loss_monitor_pkg::BUS_IDLE;
            default:
               state_ff <= input_loss_monitor_pkg::BUS_IDLE;
         endcase
      end
   end

   // event bit: a loss in the same cycle as a clear keeps the bit set
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         inputAbsentEvent_ff <=
            input_loss_monitor_pkg::EVENT_GUARD_RESET[input_loss_monitor_pkg::INPUT_EVENT_BIT];
      else if (lossPulse)
         inputAbsentEvent_ff <= 1'b1;
      else if (writeStrobe && cmd_ff == input_loss_monitor_pkg::EVENT_GUARD_OFFSET
               && rxShift_ff[input_loss_monitor_pkg::INPUT_EVENT_BIT])
         inputAbsentEvent_ff <= 1'b0;
   end

   // writing 1 locks when open and releases when locked, even under lock
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         clearableWriteGuard_ff <=
            input_loss_monitor_pkg::EVENT_GUARD_RESET[input_loss_monitor_pkg::CLEARABLE_GUARD_BIT];
      else if (writeStrobe && cmd_ff == input_loss_monitor_pkg::EVENT_GUARD_OFFSET
               && rxShift_ff[input_loss_monitor_pkg::CLEARABLE_GUARD_BIT])
         clearableWriteGuard_ff <= ~clearableWriteGuard_ff;
   end

   // no bus write can clear this guard; only reset does
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         nonclearGuard_ff <= input_loss_monitor_pkg::NONCLEAR_GUARD_RESET;
      else if (writeStrobe && !writeBlocked
               && cmd_ff == input_loss_monitor_pkg::NONCLEAR_GUARD_OFFSET
               && rxShift_ff[input_loss_monitor_pkg::NONCLEAR_GUARD_BIT])
         nonclearGuard_ff <= 1'b1;
   end

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         writeGuardActive_ff <= 1'b0;
      else
         writeGuardActive_ff <= writeBlocked;
   end

endmodule

// ### include/input_loss_monitor_pkg.sv
// constants for the input-loss monitor and its register port
package input_loss_monitor_pkg;

   // register offsets
   localparam logic [7:0] NONCLEAR_GUARD_OFFSET = 8'h26;
   localparam logic [7:0] EVENT_GUARD_OFFSET    = 8'h27;

   // field positions inside those bytes
   localparam int CLEARABLE_GUARD_BIT = 0;
   localparam int INPUT_EVENT_BIT     = 1;
   localparam int NONCLEAR_GUARD_BIT  = 0;

   // reset values
   localparam logic [7:0] EVENT_GUARD_RESET    = 8'h00;
   localparam logic       NONCLEAR_GUARD_RESET = 1'b0;

   // plain default bus address, no documented value carried here
   localparam logic [6:0] DEFAULT_BUS_ADDR = 7'h68;

   // absence detection: time without an edge before the input counts as lost
   localparam int CLOCK_HZ          = 20_000_000;
   localparam int ABSENT_TIME_NS    = 3200;
   localparam int ABSENT_CYCLES     = (ABSENT_TIME_NS * (CLOCK_HZ / 1_000_000)) / 1000;
   localparam int ABSENT_CNT_W      = 12;

   typedef enum logic [8:0] {
      BUS_IDLE     = 9'b0_0000_0001,
      BUS_ADDR     = 9'b0_0000_0010,
      BUS_ACK_ADDR = 9'b0_0000_0100,
      BUS_CMD      = 9'b0_0000_1000,
      BUS_ACK_CMD  = 9'b0_0001_0000,
      BUS_WDATA    = 9'b0_0010_0000,
      BUS_ACK_DATA = 9'b0_0100_0000,
      BUS_RDATA    = 9'b0_1000_0000,
      BUS_RACK     = 9'b1_0000_0000
   } bus_state_t;

endpackage

// ### rtl/input_absence_detector.sv
// reference clock presence detector with first-edge tracking
`timescale 1ns/1ps
module input_absence_detector #(
   parameter int ABSENT_CYCLES = input_loss_monitor_pkg::ABSENT_CYCLES,
   parameter int CNT_W         = input_loss_monitor_pkg::ABSENT_CNT_W
) (
   input  wire logic clock,
   input  wire logic sys_rst,
   input  wire logic referenceInputClock,
   output logic      absent_ff,
   output logic      firstEdgeSeen_ff,
   output logic      refLevel_ff
);

   logic             refMeta_ff;
   logic             refSync_ff;
   logic [CNT_W-1:0] idleCnt_ff;
   logic             refEdge;

   // sampled on the system clock: only references well below half its rate are seen
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         refMeta_ff  <= 1'b0;
         refSync_ff  <= 1'b0;
         refLevel_ff <= 1'b0;
      end
      else
      begin
         refMeta_ff  <= referenceInputClock;
         refSync_ff  <= refMeta_ff;
         refLevel_ff <= refSync_ff;
      end
   end

   assign refEdge = refSync_ff ^ refLevel_ff;

   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         firstEdgeSeen_ff <= 1'b0;
      else if (refEdge)
         firstEdgeSeen_ff <= 1'b1;
   end

   // absent from reset until an edge proves the input is there
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         idleCnt_ff <= '0;
         absent_ff  <= 1'b1;
      end
      else if (refEdge)
      begin
         idleCnt_ff <= '0;
         absent_ff  <= 1'b0;
      end
      else if (idleCnt_ff == CNT_W'(ABSENT_CYCLES - 1))
         absent_ff  <= 1'b1;
      else
         idleCnt_ff <= idleCnt_ff + CNT_W'(1);
   end

endmodule

// ### verification/input_loss_monitor_properties.sv
// port-level checker for the input-loss monitor, bound to its top module
`timescale 1ns/1ps
module input_loss_monitor_checker #(
   parameter logic [6:0] BUS_ADDR      = input_loss_monitor_pkg::DEFAULT_BUS_ADDR,
   parameter int         ABSENT_CYCLES = input_loss_monitor_pkg::ABSENT_CYCLES
) (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic referenceInputClock,
   input wire logic busClockIn,
   input wire logic busDataIn,
   input wire logic busDataOut_ff,
   input wire logic busDataOe_ff,
   input wire logic clockAbsentPinOut_ff,
   input wire logic clockAbsentPinOe_ff,
   input wire logic clkOutP_ff,
   input wire logic clkOutN_ff,
   input wire logic writeGuardActive_ff
);
   // margin covers the input synchroniser plus the two-cycle reaction
   localparam int LIMIT = ABSENT_CYCLES + 8;
   logic refPrev_ff;
   logic refSeen_ff;
   int   quietCnt_ff;
   wire  refEdge = referenceInputClock != refPrev_ff;
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         refPrev_ff <= 1'b0;
         refSeen_ff <= 1'b0;
      end
      else
      begin
         refPrev_ff <= referenceInputClock;
         refSeen_ff <= refSeen_ff | refEdge;
      end
   end
   // cycles since the last raw edge, saturating
   always_ff @(posedge clock or posedge sys_rst)
   begin
      if (sys_rst)
         quietCnt_ff <= 0;
      else if (refEdge)
         quietCnt_ff <= 0;
      else if (quietCnt_ff < LIMIT)
         quietCnt_ff <= quietCnt_ff + 1;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   a_pin_drives_low: assert property (!clockAbsentPinOut_ff)
      else $error("loss pin output level not low");
   a_pin_before_edge: assert property (!refSeen_ff |-> !clockAbsentPinOe_ff)
      else $error("loss pin asserted before first reference edge");
   a_pin_after_quiet: assert property (refSeen_ff && quietCnt_ff == LIMIT
      |-> clockAbsentPinOe_ff)
      else $error("loss pin not asserted after quiet input");
   a_pin_not_early: assert property ($rose(clockAbsentPinOe_ff) |-> quietCnt_ff >= ABSENT_CYCLES)
      else $error("loss pin asserted too early");
   a_pin_released_run: assert property (quietCnt_ff == 6 |-> !clockAbsentPinOe_ff)
      else $error("loss pin held while input runs");
   a_park_on_loss: assert property (refSeen_ff && quietCnt_ff == LIMIT
      |-> !clkOutP_ff && !clkOutN_ff)
      else $error("clock path not parked low after loss");
   a_bus_out_low: assert property (!busDataOut_ff)
      else $error("bus data output level not low");
   a_clk_never_high: assert property (!(clkOutP_ff && clkOutN_ff))
      else $error("both clock outputs high");
   a_guard_on_ack: assert property ($changed(writeGuardActive_ff) |-> ##[0:2] busDataOe_ff)
      else $error("write guard changed outside a data acknowledge");
   c_loss: cover property ($rose(clockAbsentPinOe_ff));
   c_lock: cover property ($rose(writeGuardActive_ff));
   c_unlock: cover property ($fell(writeGuardActive_ff));
endmodule
bind input_loss_monitor_write_lock input_loss_monitor_checker #(
   .BUS_ADDR(BUS_ADDR),
   .ABSENT_CYCLES(ABSENT_CYCLES)
) props (
   .clock(clock),
   .sys_rst(sys_rst),
   .referenceInputClock(referenceInputClock),
   .busClockIn(busClockIn),
   .busDataIn(busDataIn),
   .busDataOut_ff(busDataOut_ff),
   .busDataOe_ff(busDataOe_ff),
   .clockAbsentPinOut_ff(clockAbsentPinOut_ff),
   .clockAbsentPinOe_ff(clockAbsentPinOe_ff),
   .clkOutP_ff(clkOutP_ff),
   .clkOutN_ff(clkOutN_ff),
   .writeGuardActive_ff(writeGuardActive_ff)
);

// ### verification/smbus_host_model.sv
// behavioural bus host for the register port, pull-up on the data line
`timescale 1ns/1ps
module smbus_host_model #(
   parameter logic [6:0] ADDR = input_loss_monitor_pkg::DEFAULT_BUS_ADDR,
   parameter int         Q    = 10
) (
   input  wire logic clock,
   input  wire logic busDataOe_ff,
   output logic      busClockIn,
   output logic      busDataIn
);
   logic sdaRel;
   // wired-and: low whenever either side pulls
   assign busDataIn = sdaRel & ~busDataOe_ff;
   initial
   begin
      busClockIn = 1'b1;
      sdaRel = 1'b1;
   end
   task automatic qtr;
      repeat (Q) @(negedge clock);
   endtask
   task automatic bitx(input logic b, output logic r);
      sdaRel = b;
      qtr();
      busClockIn = 1'b1;
      qtr();
      r = busDataIn;
      qtr();
      busClockIn = 1'b0;
      qtr();
   endtask
   task automatic start;
      sdaRel = 1'b1;
      qtr();
      busClockIn = 1'b1;
      qtr();
      sdaRel = 1'b0;
      qtr();
      busClockIn = 1'b0;
      qtr();
   endtask
   task automatic stop;
      sdaRel = 1'b0;
      qtr();
      busClockIn = 1'b1;
      qtr();
      sdaRel = 1'b1;
      qtr();
   endtask
   task automatic sendb(input logic [7:0] v, output logic a);
      logic r;
      for (int i = 7; i >= 0; i--)
         bitx(v[i], r);
      bitx(1'b1, r);
      a = ~r;
   endtask
   task automatic recvb(input logic more, output logic [7:0] v);
      logic r;
      for (int i = 7; i >= 0; i--)
      begin
         bitx(1'b1, r);
         v[i] = r;
      end
      // ack asks for the next offset, nack ends the read
      bitx(~more, r);
   endtask
   task automatic probe(input logic [6:0] a, output logic ok);
      start();
      sendb({a, 1'b0}, ok);
      stop();
   endtask
   task automatic read_two(input logic [7:0] off, output logic [15:0] d, output logic ok);
      logic a0;
      logic a1;
      logic a2;
      start();
      sendb({ADDR, 1'b0}, a0);
      sendb(off, a1);
      start();
      sendb({ADDR, 1'b1}, a2);
      recvb(1'b1, d[15:8]);
      recvb(1'b0, d[7:0]);
      stop();
      ok = a0 & a1 & a2;
   endtask
   task automatic write_reg(input logic [7:0] off, input logic [7:0] d, output logic ok);
      logic a0;
      logic a1;
      logic a2;
      start();
      sendb({ADDR, 1'b0}, a0);
      sendb(off, a1);
      sendb(d, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   task automatic read_reg(input logic [7:0] off, output logic [7:0] d, output logic ok);
      logic a0;
      logic a1;
      logic a2;
      start();
      sendb({ADDR, 1'b0}, a0);
      sendb(off, a1);
      start();
      sendb({ADDR, 1'b1}, a2);
      recvb(1'b0, d);
      stop();
      ok = a0 & a1 & a2;
   endtask
endmodule

// ### verification/input_loss_monitor_write_lock_tb.sv
// self-checking bench for the input-loss monitor and write guards
`timescale 1ns/1ps
module input_loss_monitor_write_lock_tb;
   localparam int ABSENT = 24;
   logic       clock;
   logic       sys_rst;
   logic       refClk;
   logic       refRun;
   logic [2:0] refCnt;
   wire        busClockIn;
   wire        busDataIn;
   wire        busDataOut_ff;
   wire        busDataOe_ff;
   wire        clockAbsentPinOut_ff;
   wire        clockAbsentPinOe_ff;
   wire        clkOutP_ff;
   wire        clkOutN_ff;
   wire        writeGuardActive_ff;
   int         failures;
   int         total_checks;
   input_loss_monitor_write_lock #(.ABSENT_CYCLES(ABSENT)) dut (
      .clock(clock),
      .sys_rst(sys_rst),
      .referenceInputClock(refClk),
      .busClockIn(busClockIn),
      .busDataIn(busDataIn),
      .busDataOut_ff(busDataOut_ff),
      .busDataOe_ff(busDataOe_ff),
      .clockAbsentPinOut_ff(clockAbsentPinOut_ff),
      .clockAbsentPinOe_ff(clockAbsentPinOe_ff),
      .clkOutP_ff(clkOutP_ff),
      .clkOutN_ff(clkOutN_ff),
      .writeGuardActive_ff(writeGuardActive_ff)
   );
   smbus_host_model host (
      .clock(clock),
      .busDataOe_ff(busDataOe_ff),
      .busClockIn(busClockIn),
      .busDataIn(busDataIn)
   );
   initial
   begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   // reference toggles every 8 cycles, well under the detector's limit
   always @(negedge clock)
   begin
      if (refRun)
      begin
         refCnt <= refCnt + 3'h1;
         if (refCnt == 3'h7)
            refClk <= ~refClk;
      end
   end
   task automatic final_report;
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] off, input logic [7:0] d);
      logic ok;
      host.write_reg(off, d, ok);
      check({7'h0, ok}, 8'h01);
   endtask
   task automatic rd_chk(input logic [7:0] off, input logic [7:0] exp);
      logic [7:0] d;
      logic       ok;
      host.read_reg(off, d, ok);
      check({7'h0, ok}, 8'h01);
      check(d, exp);
   endtask
   task automatic wait_pin(input logic exp);
      for (int n = 0; n < 200 && clockAbsentPinOe_ff !== exp; n++)
         @(negedge clock);
      check({7'h0, clockAbsentPinOe_ff}, {7'h0, exp});
      if (clockAbsentPinOe_ff !== exp)
         final_report();
   endtask
   task automatic test_reset;
      logic ok;
      repeat (60) @(negedge clock);
      check({4'h0, clockAbsentPinOe_ff, clkOutP_ff, clkOutN_ff, writeGuardActive_ff}, 8'h00);
      rd_chk(input_loss_monitor_pkg::EVENT_GUARD_OFFSET, 8'h00);
      rd_chk(input_loss_monitor_pkg::NONCLEAR_GUARD_OFFSET, 8'h00);
      rd_chk(8'h30, 8'h00);
      host.probe(7'h11, ok);
      check({7'h0, ok}, 8'h00);
      $display("test reset done");
   endtask
   task automatic test_loss;
      refRun = 1'b1;
      repeat (100) @(negedge clock);
      check({7'h0, clkOutP_ff ^ clkOutN_ff}, 8'h01);
      wait_pin(1'b0);
      refRun = 1'b0;
      wait_pin(1'b1);
      check({4'h0, clockAbsentPinOe_ff, clkOutP_ff, clkOutN_ff, writeGuardActive_ff}, 8'h08);
      rd_chk(8'h27, 8'h02);
      refRun = 1'b1;
      wait_pin(1'b0);
      rd_chk(8'h27, 8'h02);
      wr(8'h27, 8'h00);
      rd_chk(8'h27, 8'h02);
      $display("test loss done");
   endtask
   task automatic test_guard;
      logic [15:0] pair;
      logic        ok;
      wr(8'h27, 8'h01);
      check({7'h0, writeGuardActive_ff}, 8'h01);
      rd_chk(8'h27, 8'h03);
      host.read_two(8'h26, pair, ok);
      check({7'h0, ok}, 8'h01);
      check(pair[15:8], 8'h00);
      check(pair[7:0], 8'h03);
      wr(8'h27, 8'h02);
      rd_chk(8'h27, 8'h01);
      wr(8'h26, 8'h01);
      wr(8'h27, 8'h01);
      check({7'h0, writeGuardActive_ff}, 8'h00);
      rd_chk(8'h26, 8'h00);
      $display("test guard done");
   endtask
   task automatic test_nonclear;
      wr(8'h26, 8'h01);
      check({7'h0, writeGuardActive_ff}, 8'h01);
      wr(8'h26, 8'h01);
      wr(8'h27, 8'h01);
      wr(8'h27, 8'h01);
      check({7'h0, writeGuardActive_ff}, 8'h01);
      rd_chk(8'h26, 8'h01);
      rd_chk(8'h27, 8'h00);
      sys_rst = 1'b1;
      repeat (3) @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      check({7'h0, writeGuardActive_ff}, 8'h00);
      rd_chk(8'h26, 8'h00);
      rd_chk(8'h27, 8'h00);
      $display("test nonclear done");
   endtask
   initial
   begin
      sys_rst = 1'b1;
      refClk = 1'b0;
      refRun = 1'b0;
      refCnt = 3'h0;
      failures = 0;
      total_checks = 0;
      repeat (3) @(negedge clock);
      sys_rst = 1'b0;
      repeat (4) @(negedge clock);
      test_reset();
      test_loss();
      test_guard();
      test_nonclear();
      final_report();
   end
   initial
   begin
      repeat (100000) @(posedge clock);
      failures++;
      final_report();
   end
endmodule
